/* File: src/ixsb_slave.sv */
// i2c and spi slave giving a serial master access to uart registers
// assumes the uart side samples reg_* strobes on core_clk and
// presents reg_rdata in the cycle reg_rd is high
`timescale 1ns/1ps
module ixsb_slave (
  input  wire logic       core_clk,
  input  wire logic       reset,
  input  wire logic       scl_in,
  input  wire logic       sda_in,
  output logic            sda_out,
  output logic            sda_oe,
  input  wire logic       addr_strap_upper,
  input  wire logic       addr_strap_lower,
  input  wire logic       spi_sclk,
  input  wire logic       spi_cs_n,
  input  wire logic       spi_si,
  output logic            spi_so,
  output logic            spi_so_oe,
  output logic            reg_wr,
  output logic            reg_rd,
  output logic            reg_chan,
  output logic [3:0]      reg_index,
  output logic [7:0]      reg_wdata,
  input  wire logic [7:0] reg_rdata,
  input  wire logic [1:0] tx_full
);

  // core clock must oversample the fastest i2c half period
  if (ixsb_pkg::I2C_HALF_CYC <= 2 * ixsb_pkg::SYNC_LAT) begin : g_chk
    $error("core clock too slow for fast-mode i2c");
  end

  // ****************************************
  // pin synchronisers
  // ****************************************
  logic [3:0] pin_s;
  logic       scl_s;
  logic       sda_s;
  logic       up_s;
  logic       lo_s;
  logic [1:0] tgl_s;
  logic       wr_tgl_q;
  logic       rd_tgl_q;

  ixsb_sync #(.W(4)) u_pin_sync (
    .core_clk (core_clk),
    .reset    (reset),
    .async_i  ({scl_in, sda_in, addr_strap_upper, addr_strap_lower}),
    .sync_o   (pin_s)
  );

  ixsb_sync #(.W(2)) u_tgl_sync (
    .core_clk (core_clk),
    .reset    (reset),
    .async_i  ({wr_tgl_q, rd_tgl_q}),
    .sync_o   (tgl_s)
  );

  assign scl_s = pin_s[3];
  assign sda_s = pin_s[2];
  assign up_s  = pin_s[1];
  assign lo_s  = pin_s[0];

  // ****************************************
  // i2c bus conditions
  // ****************************************
  logic scl_d_q;
  logic sda_d_q;
  logic scl_rise;
  logic scl_fall;
  logic bus_start;
  logic bus_stop;

  // edge stage reads synchronised copies only
  always_ff @(posedge core_clk) begin
    if (reset) begin
      scl_d_q <= 1'b0;
      sda_d_q <= 1'b0;
    end else begin
      scl_d_q <= scl_s;
      sda_d_q <= sda_s;
    end
  end

  assign scl_rise  = scl_s & ~scl_d_q;
  assign scl_fall  = ~scl_s & scl_d_q;
  assign bus_start = scl_s & scl_d_q & sda_d_q & ~sda_s;
  assign bus_stop  = scl_s & scl_d_q & ~sda_d_q & sda_s;

  // ****************************************
  // strap sensing
  // ****************************************
  logic       idle_lo_q;
  logic       st_up_q;
  logic       st_lo_q;
  logic       armed_q;
  logic [7:0] slave_addr_q;

  // lower strap seen idle/start/first-fall tells vdd, gnd, scl, sda apart;
  // upper strap at start reads low for gnd or sda, which pick the high group
  always_ff @(posedge core_clk) begin
    if (reset) begin
      idle_lo_q    <= 1'b0;
      st_up_q      <= 1'b0;
      st_lo_q      <= 1'b0;
      armed_q      <= 1'b0;
      slave_addr_q <= ixsb_pkg::ADDR_BASE;
    end else begin
      if (scl_s && sda_s) begin
        idle_lo_q <= lo_s;
      end
      if (bus_start) begin
        st_up_q <= up_s;
        st_lo_q <= lo_s;
        armed_q <= 1'b1;
      end else if (scl_fall && armed_q) begin
        armed_q      <= 1'b0;
        slave_addr_q <= ixsb_pkg::ADDR_BASE +
                        {4'h0, ~st_up_q, idle_lo_q & ~lo_s, ~st_lo_q, 1'b0};
      end
    end
  end

  // ****************************************
  // i2c byte engine
  // ****************************************
  ixsb_pkg::ixsb_i2c_state_t state_q;
  logic [3:0] cnt_q;
  logic [7:0] shift_q;
  logic [7:0] sub_q;
  logic       rw_q;
  logic       mack_q;
  logic       drive_q;
  logic       i2c_wr_q;
  logic       i2c_rd_q;
  logic [7:0] i2c_wdata_q;
  logic [7:0] rdata_q;
  logic       rd_done_q;
  logic       addr_hit;
  logic       wr_full;

  assign addr_hit = shift_q[7:1] == slave_addr_q[7:1];
  assign wr_full  = (sub_q[ixsb_pkg::IDX_HI:ixsb_pkg::IDX_LO] == ixsb_pkg::TX_HOLD_IDX) &&
                    tx_full[sub_q[ixsb_pkg::CHAN_LO]];

  // data changes only after scl falls, so it is stable while scl is high
  always_ff @(posedge core_clk) begin
    if (reset) begin
      state_q     <= ixsb_pkg::I2C_IDLE;
      cnt_q       <= 4'h0;
      shift_q     <= 8'h00;
      sub_q       <= 8'h00;
      rw_q        <= 1'b0;
      mack_q      <= 1'b0;
      drive_q     <= 1'b0;
      i2c_wr_q    <= 1'b0;
      i2c_rd_q    <= 1'b0;
      i2c_wdata_q <= 8'h00;
    end else begin
      i2c_wr_q <= 1'b0;
      i2c_rd_q <= 1'b0;
      if (bus_stop) begin
        state_q <= ixsb_pkg::I2C_IDLE;
        drive_q <= 1'b0;
      end else if (bus_start) begin
        state_q <= ixsb_pkg::I2C_ADDR;
        cnt_q   <= 4'h0;
        drive_q <= 1'b0;
      end else if (scl_rise) begin
        if (state_q == ixsb_pkg::I2C_RACK) begin
          mack_q <= ~sda_s;
        end else if (state_q != ixsb_pkg::I2C_IDLE && cnt_q != ixsb_pkg::BITS_PER_BYTE) begin
          cnt_q <= cnt_q + 4'h1;
          if (state_q != ixsb_pkg::I2C_RDATA) begin
            shift_q <= {shift_q[6:0], sda_s};
          end
        end
      end else if (scl_fall) begin
        case (state_q)
          ixsb_pkg::I2C_ADDR: begin
            if (cnt_q == ixsb_pkg::BITS_PER_BYTE) begin
              if (addr_hit) begin
                state_q <= ixsb_pkg::I2C_AACK;
                drive_q <= 1'b1;
                rw_q    <= shift_q[ixsb_pkg::I2C_DIR_BIT];
              end else begin
                state_q <= ixsb_pkg::I2C_IDLE;
              end
            end
          end
          ixsb_pkg::I2C_AACK: begin
            drive_q <= 1'b0;
            cnt_q   <= 4'h0;
            if (rw_q) begin
              state_q  <= ixsb_pkg::I2C_RPREP;
              i2c_rd_q <= 1'b1;
            end else begin
              state_q <= ixsb_pkg::I2C_SUB;
            end
          end
          ixsb_pkg::I2C_SUB: begin
            if (cnt_q == ixsb_pkg::BITS_PER_BYTE) begin
              sub_q   <= shift_q;
              drive_q <= 1'b1;
              state_q <= ixsb_pkg::I2C_SACK;
            end
          end
          ixsb_pkg::I2C_WDATA: begin
            if (cnt_q == ixsb_pkg::BITS_PER_BYTE) begin
              drive_q     <= ~wr_full;
              i2c_wr_q    <= ~wr_full;
              i2c_wdata_q <= shift_q;
              state_q     <= ixsb_pkg::I2C_WACK;
            end
          end
          ixsb_pkg::I2C_SACK, ixsb_pkg::I2C_WACK: begin
            drive_q <= 1'b0;
            cnt_q   <= 4'h0;
            state_q <= ixsb_pkg::I2C_WDATA;
          end
          ixsb_pkg::I2C_RDATA: begin
            if (cnt_q == ixsb_pkg::BITS_PER_BYTE) begin
              drive_q <= 1'b0;
              state_q <= ixsb_pkg::I2C_RACK;
            end else begin
              drive_q <= ~shift_q[7];
              shift_q <= {shift_q[6:0], 1'b0};
            end
          end
          ixsb_pkg::I2C_RACK: begin
            cnt_q <= 4'h0;
            if (mack_q) begin
              state_q  <= ixsb_pkg::I2C_RPREP;
              i2c_rd_q <= 1'b1;
            end else begin
              state_q <= ixsb_pkg::I2C_IDLE;
            end
          end
          default: begin
            drive_q <= drive_q;
          end
        endcase
      end else if (state_q == ixsb_pkg::I2C_RPREP && rd_done_q) begin
        // scl is low here; first bit goes out as soon as data lands
        state_q <= ixsb_pkg::I2C_RDATA;
        drive_q <= ~rdata_q[7];
        shift_q <= {rdata_q[6:0], 1'b0};
      end
    end
  end

  // open drain: only ever pull low
  assign sda_out = 1'b0;
  assign sda_oe  = drive_q;

  // ****************************************
  // spi link domain
  // ****************************************
  logic       link_rst_q;
  logic [4:0] scnt_q;
  logic [6:0] sin_q;
  logic [7:0] spi_cmd_q;
  logic [7:0] spi_wdata_q;
  logic [7:0] sout_q;

  // toggles must survive deselect, so they take the core reset
  always_ff @(posedge core_clk) begin
    link_rst_q <= reset;
  end

  // frame logic is cleared by deselect; clock only runs inside a frame
  always_ff @(posedge spi_sclk or posedge spi_cs_n) begin
    if (spi_cs_n) begin
      scnt_q <= 5'h00;
      sin_q  <= 7'h00;
    end else begin
      sin_q <= {sin_q[5:0], spi_si};
      if (scnt_q != ixsb_pkg::SPI_CNT_MAX) begin
        scnt_q <= scnt_q + 5'h01;
      end
    end
  end

  // read is requested one edge early, bit 0 being reserved, to give
  // the core time to fetch before the data byte starts
  always_ff @(posedge spi_sclk or posedge link_rst_q) begin
    if (link_rst_q) begin
      rd_tgl_q    <= 1'b0;
      wr_tgl_q    <= 1'b0;
      spi_cmd_q   <= 8'h00;
      spi_wdata_q <= 8'h00;
    end else if (!spi_cs_n) begin
      if (scnt_q == ixsb_pkg::SPI_RD_EDGE) begin
        spi_cmd_q <= {sin_q[5:0], spi_si, 1'b0};
        if (sin_q[5]) begin
          rd_tgl_q <= ~rd_tgl_q;
        end
      end
      if (scnt_q == ixsb_pkg::SPI_WR_EDGE && !spi_cmd_q[ixsb_pkg::SPI_DIR_BIT]) begin
        spi_wdata_q <= {sin_q, spi_si};
        wr_tgl_q    <= ~wr_tgl_q;
      end
    end
  end

  // rdata_q is quiet by then: the core wrote it well before this edge
  always_ff @(negedge spi_sclk or posedge spi_cs_n) begin
    if (spi_cs_n) begin
      sout_q <= 8'h00;
    end else if (scnt_q == ixsb_pkg::SPI_DATA_EDGE) begin
      sout_q <= rdata_q;
    end else begin
      sout_q <= {sout_q[6:0], 1'b0};
    end
  end

  assign spi_so    = sout_q[7];
  assign spi_so_oe = ~spi_cs_n;

  // ****************************************
  // spi events in the core domain
  // ****************************************
  logic [1:0] tgl_d_q;
  logic       spi_wr_ev;
  logic       spi_rd_ev;

  always_ff @(posedge core_clk) begin
    if (reset) begin
      tgl_d_q <= 2'h0;
    end else begin
      tgl_d_q <= tgl_s;
    end
  end

  assign spi_wr_ev = tgl_s[1] ^ tgl_d_q[1];
  assign spi_rd_ev = tgl_s[0] ^ tgl_d_q[0];

  // ****************************************
  // register port
  // ****************************************
  logic       acc_wr;
  logic       acc_rd;
  logic [3:0] acc_idx;
  logic [1:0] acc_chan;
  logic [7:0] acc_data;
  logic       acc_full;
  logic       acc_ok;

  // i2c wins; both masters at once is a system fault anyway
  always_comb begin
    acc_wr   = 1'b0;
    acc_rd   = 1'b0;
    acc_idx  = 4'h0;
    acc_chan = ixsb_pkg::CHAN_A;
    acc_data = 8'h00;
    if (i2c_wr_q || i2c_rd_q) begin
      acc_wr   = i2c_wr_q;
      acc_rd   = i2c_rd_q;
      acc_idx  = sub_q[ixsb_pkg::IDX_HI:ixsb_pkg::IDX_LO];
      acc_chan = sub_q[ixsb_pkg::CHAN_HI:ixsb_pkg::CHAN_LO];
      acc_data = i2c_wdata_q;
    end else if (spi_wr_ev || spi_rd_ev) begin
      acc_wr   = spi_wr_ev;
      acc_rd   = spi_rd_ev;
      acc_idx  = spi_cmd_q[ixsb_pkg::IDX_HI:ixsb_pkg::IDX_LO];
      acc_chan = spi_cmd_q[ixsb_pkg::CHAN_HI:ixsb_pkg::CHAN_LO];
      acc_data = spi_wdata_q;
    end
  end

  assign acc_full = (acc_idx == ixsb_pkg::TX_HOLD_IDX) && tx_full[acc_chan[0]];
  assign acc_ok   = (acc_chan == ixsb_pkg::CHAN_A) || (acc_chan == ixsb_pkg::CHAN_B);

  // strobes and fields registered; reserved channels never reach the uart
  always_ff @(posedge core_clk) begin
    if (reset) begin
      reg_wr    <= 1'b0;
      reg_rd    <= 1'b0;
      reg_chan  <= 1'b0;
      reg_index <= 4'h0;
      reg_wdata <= 8'h00;
    end else begin
      reg_wr <= acc_wr & acc_ok & ~acc_full;
      reg_rd <= acc_rd & acc_ok;
      if (acc_wr || acc_rd) begin
        reg_chan  <= acc_chan[0];
        reg_index <= acc_idx;
        reg_wdata <= acc_data;
      end
    end
  end

  // read data captured; a read of the rx holding index pops the fifo
  always_ff @(posedge core_clk) begin
    if (reset) begin
      rdata_q   <= 8'h00;
      rd_done_q <= 1'b0;
    end else begin
      rd_done_q <= reg_rd;
      if (reg_rd) begin
        rdata_q <= reg_rdata;
      end
    end
  end

  // ****************************************
  // assertions
  // ****************************************
  AST_ACK_MATCH: assert property (@(posedge core_clk) disable iff (reset)
    state_q == ixsb_pkg::I2C_ADDR && scl_fall && !bus_start && !bus_stop &&
    cnt_q == ixsb_pkg::BITS_PER_BYTE && addr_hit |=> sda_oe && state_q == ixsb_pkg::I2C_AACK)
    else $error("matching address not acknowledged");

  AST_NO_ACK_FOREIGN: assert property (@(posedge core_clk) disable iff (reset)
    state_q == ixsb_pkg::I2C_ADDR && scl_fall && !bus_start && !bus_stop &&
    cnt_q == ixsb_pkg::BITS_PER_BYTE && !addr_hit |=> !sda_oe ##1 !sda_oe)
    else $error("foreign address acknowledged");

  AST_NACK_FULL: assert property (@(posedge core_clk) disable iff (reset)
    state_q == ixsb_pkg::I2C_WDATA && scl_fall && !bus_start && !bus_stop &&
    cnt_q == ixsb_pkg::BITS_PER_BYTE && wr_full |=> !sda_oe && !i2c_wr_q ##1 !reg_wr)
    else $error("write into full fifo not refused");

  AST_FULL_DISCARD: assert property (@(posedge core_clk) disable iff (reset)
    acc_wr && acc_full |=> !reg_wr)
    else $error("write into full fifo passed on");

  AST_STOP_ENDS: assert property (@(posedge core_clk) disable iff (reset)
    bus_stop |=> state_q == ixsb_pkg::I2C_IDLE && !sda_oe)
    else $error("stop did not end access");

  AST_READ_DIR: assert property (@(posedge core_clk) disable iff (reset)
    state_q == ixsb_pkg::I2C_AACK && scl_fall && !bus_start && !bus_stop && rw_q
    |=> i2c_rd_q ##1 (reg_rd == (sub_q[ixsb_pkg::CHAN_HI] == 1'b0)))
    else $error("read direction did not fetch");

  AST_SUB_ROUTE: assert property (@(posedge core_clk) disable iff (reset)
    i2c_wr_q && !sub_q[ixsb_pkg::CHAN_HI] && !wr_full
    |=> reg_wr && reg_index == $past(sub_q[6:3]) && reg_chan == $past(sub_q[1]))
    else $error("sub-address fields misrouted");

  AST_RES_CHAN: assert property (@(posedge core_clk) disable iff (reset)
    (acc_wr || acc_rd) && acc_chan[1] |=> !reg_wr && !reg_rd)
    else $error("reserved channel reached uart");

  AST_ADDR_RANGE: assert property (@(posedge core_clk) disable iff (reset)
    (slave_addr_q[7:1] & ixsb_pkg::ADDR_BUS_MSK) == ixsb_pkg::ADDR_BUS_FIX && !slave_addr_q[0])
    else $error("slave address outside strap range");

  AST_RD_FIRST_BIT: assert property (@(posedge core_clk) disable iff (reset)
    state_q == ixsb_pkg::I2C_RPREP && rd_done_q && !scl_rise && !scl_fall && !bus_start && !bus_stop
    |=> state_q == ixsb_pkg::I2C_RDATA && sda_oe == !rdata_q[7])
    else $error("read byte not presented");

  AST_SPI_RD_REQ: assert property (@(posedge spi_sclk) disable iff (spi_cs_n)
    scnt_q == ixsb_pkg::SPI_RD_EDGE && sin_q[5] |=> rd_tgl_q != $past(rd_tgl_q))
    else $error("spi read command not forwarded");

endmodule : ixsb_slave

/* File: src/ixsb_pkg.sv */
// constants shared by the serial register access slave
// assumes a 100 MHz core clock and an 8-bit UART register port beyond it
package ixsb_pkg;

  // ****************************************
  // slave address straps
  // ****************************************
  localparam logic [7:0] ADDR_BASE    = 8'h60;  // lowest strap-selected address
  localparam logic [6:0] ADDR_BUS_FIX = 7'h30;  // upper bits common to every choice
  localparam logic [6:0] ADDR_BUS_MSK = 7'h78;

  // ****************************************
  // command and sub-address fields
  // ****************************************
  localparam int I2C_DIR_BIT = 0;
  localparam int SPI_DIR_BIT = 7;
  localparam int IDX_HI      = 6;
  localparam int IDX_LO      = 3;
  localparam int CHAN_HI     = 2;
  localparam int CHAN_LO     = 1;

  localparam logic [3:0] TX_HOLD_IDX = 4'h0;  // tx_holding_port on write
  localparam logic [3:0] RX_HOLD_IDX = 4'h0;  // rx_holding_port on read
  localparam logic [1:0] CHAN_A      = 2'h0;
  localparam logic [1:0] CHAN_B      = 2'h1;

  // ****************************************
  // timing
  // ****************************************
  localparam int CORE_CLK_MHZ  = 100;
  localparam int I2C_STD_KBPS  = 100;
  localparam int I2C_FAST_KBPS = 400;
  localparam int SPI_MAX_MHZ   = 33;
  localparam int I2C_HALF_NS   = 1000000 / (2 * I2C_FAST_KBPS);
  localparam int I2C_HALF_CYC  = (I2C_HALF_NS * CORE_CLK_MHZ) / 1000;
  localparam int SYNC_LAT      = 3;           // two sync flops plus edge stage
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  localparam logic [4:0] SPI_RD_EDGE   = 5'h06; // rising edge after which bits 7..1 are in
  localparam logic [4:0] SPI_WR_EDGE   = 5'h0F;
  localparam logic [4:0] SPI_DATA_EDGE = 5'h08;
  localparam logic [4:0] SPI_CNT_MAX   = 5'h10;

  // ****************************************
  // i2c engine states
  // ****************************************
  typedef enum logic [9:0] {
    I2C_IDLE  = 10'h001,
    I2C_ADDR  = 10'h002,
    I2C_AACK  = 10'h004,
    I2C_SUB   = 10'h008,
    I2C_SACK  = 10'h010,
    I2C_WDATA = 10'h020,
    I2C_WACK  = 10'h040,
    I2C_RPREP = 10'h080,
    I2C_RDATA = 10'h100,
    I2C_RACK  = 10'h200
  } ixsb_i2c_state_t;

endpackage : ixsb_pkg

/* File: src/ixsb_sync.sv */
// two-flop level synchroniser, one per bit of a bus
// assumes each bit is an independent level; no bus coherency
`timescale 1ns/1ps
module ixsb_sync #(
  parameter int W = 1
) (
  input  wire logic         core_clk,
  input  wire logic         reset,
  input  wire logic [W-1:0] async_i,
  output logic      [W-1:0] sync_o
);

  logic [W-1:0] meta_q;

  // first stage feeds only the second
  always_ff @(posedge core_clk) begin
    if (reset) begin
      meta_q <= '0;
      sync_o <= '0;
    end else begin
      meta_q <= async_i;
      sync_o <= meta_q;
    end
  end

endmodule : ixsb_sync

/* File: bench/ixsb_host_model.sv */
// serial master model: i2c master at 400 kbps and spi mode 0 master
// assumes an sda pull-up outside; i2c tasks are entered on a core_clk fall
`timescale 1ns/1ps
module ixsb_host_model (
  output logic      scl,
  output logic      sda_oe,
  input  wire logic sda,
  output logic      spi_sclk,
  output logic      spi_cs_n,
  output logic      spi_si,
  input  wire logic spi_so
);
  // ****************************************
  // master tasks
  // ****************************************
  localparam int Q = 630;  // quarter bit; 2520 ns keeps the bit under 400 kbps

  // lines idle: clock high, sda released, spi deselected with clock low
  initial begin
    scl = 1'b1;
    sda_oe = 1'b0;
    spi_sclk = 1'b0;
    spi_cs_n = 1'b1;
    spi_si = 1'b0;
  end

  // start or repeated start, clock left low
  task automatic start;
    if (scl === 1'b0) begin
      sda_oe = 1'b0;
      #Q scl = 1'b1;
      #Q;
    end
    sda_oe = 1'b1;
    #Q scl = 1'b0;
    #Q;
  endtask : start

  // one clock pulse, sda sampled mid-high
  task automatic pulse(output logic s);
    #Q scl = 1'b1;
    #Q s = sda;
    #Q scl = 1'b0;
    #Q;
  endtask : pulse

  // byte out msb first, then the ack slot (0 = ack)
  task automatic put_byte(input logic [7:0] b, output logic ack);
    for (int i = 7; i >= 0; i--) begin
      sda_oe = ~b[i];
      pulse(ack);
    end
    sda_oe = 1'b0;
    pulse(ack);
  endtask : put_byte

  // byte in, then our ack (0) or nack (1)
  task automatic get_byte(output logic [7:0] b, input logic nack);
    logic s;
    sda_oe = 1'b0;
    for (int i = 7; i >= 0; i--) begin
      pulse(b[i]);
    end
    sda_oe = ~nack;
    pulse(s);
    sda_oe = 1'b0;
  endtask : get_byte

  // stop, then idle with the clock high
  task automatic stop;
    sda_oe = 1'b1;
    #Q scl = 1'b1;
    #Q sda_oe = 1'b0;
    #(2 * Q);
  endtask : stop

  // one spi frame: command byte, then data byte; sampled at rising edges
  task automatic spi_frame(input logic [7:0] cmd, input logic [7:0] wd, output logic [7:0] rd);
    spi_cs_n = 1'b0;
    for (int i = 15; i >= 0; i--) begin
      spi_si = (i > 7) ? cmd[i-8] : wd[i];
      #62.5 spi_sclk = 1'b1;
      if (i < 8) rd[i] = spi_so;
      #62.5 spi_sclk = 1'b0;
    end
    #62.5 spi_cs_n = 1'b1;
    spi_si = ~spi_si;  // released line shows no stale level
    #100;
  endtask : spi_frame
endmodule : ixsb_host_model

/* File: bench/test_ixsb_slave.sv */
// self-checking bench for the serial register access slave
// assumes the host model on both links and a monitor of the register strobes
`timescale 1ns/1ps
module test_ixsb_slave;
  // ****************************************
  // bench top
  // ****************************************
  logic       core_clk = 1'b0;
  logic       reset = 1'b1;
  logic [1:0] up_sel = 2'h0;  // strap code: 0 supply, 1 ground, 2 clock, 3 data
  logic [1:0] lo_sel = 2'h0;
  logic [7:0] reg_rdata = 8'h00;
  logic [1:0] tx_full = 2'h0;
  logic       scl, host_oe, sda_out, sda_oe, spi_sclk, spi_cs_n, spi_si, spi_so, spi_so_oe;
  logic       reg_wr, reg_rd, reg_chan, a;
  logic [3:0] reg_index;
  logic [7:0] reg_wdata, b;
  logic [12:0] wr_last = 13'h0000;
  logic [4:0] rd_last = 5'h00;
  int         wr_n = 0, rd_n = 0, err_total = 0, n_compared = 0, n0, r0;
  wire        sda = ~(host_oe | (sda_oe & ~sda_out));  // pulled up

  function automatic logic strap(input logic [1:0] c, input logic s, input logic d);
    return (c == 2'h0) ? 1'b1 : (c == 2'h1) ? 1'b0 : (c == 2'h2) ? s : d;
  endfunction : strap

  ixsb_slave u_ixsb_slave (.core_clk(core_clk), .reset(reset), .scl_in(scl), .sda_in(sda),
    .sda_out(sda_out), .sda_oe(sda_oe), .addr_strap_upper(strap(up_sel, scl, sda)),
    .addr_strap_lower(strap(lo_sel, scl, sda)), .spi_sclk(spi_sclk), .spi_cs_n(spi_cs_n),
    .spi_si(spi_si), .spi_so(spi_so), .spi_so_oe(spi_so_oe), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_chan(reg_chan), .reg_index(reg_index), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .tx_full(tx_full));
  ixsb_host_model u_ixsb_host_model (.scl(scl), .sda_oe(host_oe), .sda(sda), .spi_sclk(spi_sclk),
    .spi_cs_n(spi_cs_n), .spi_si(spi_si), .spi_so(spi_so));

  always #5 core_clk = ~core_clk;

  // strobe monitor: counts and remembers the last access of each kind
  always @(posedge core_clk) begin
    if (reg_wr === 1'b1) begin
      wr_n++;
      wr_last = {reg_chan, reg_index, reg_wdata};
    end
    if (reg_rd === 1'b1) begin
      rd_n++;
      rd_last = {reg_chan, reg_index};
    end
  end

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    n_compared++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic end_of_test;
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : end_of_test

  // eight of the sixteen strap pairings, each lower code twice, answer at their own address; a foreign one is ignored
  task automatic t_straps;
    for (int i = 0; i < 9; i++) begin
      @(negedge core_clk);
      up_sel = i[1:0];
      lo_sel = (i == 8) ? 2'h0 : i[2:1];
      #1260;
      u_ixsb_host_model.start();
      // the last pass writes to an in-range address that the straps do not pick
      u_ixsb_host_model.put_byte(8'h60 + (i[0] ? 8'h08 : 8'h00) + {5'h00, i[2:1], 1'b0} +
                                 ((i == 8) ? 8'h02 : 8'h00), a);
      if (i < 8) chk("strap ack", 16'h0000, {15'h0000, a});
      else chk("foreign nack", 16'h0001, {15'h0000, a});
      u_ixsb_host_model.stop();
    end
  endtask : t_straps

  // i2c write to address 0x60: sub, data, expected ack and strobe
  task automatic i2c_wr(input logic [7:0] sub, input logic [7:0] d, input logic eack, input logic [12:0] elast);
    @(negedge core_clk);
    n0 = wr_n;
    u_ixsb_host_model.start();
    u_ixsb_host_model.put_byte(8'h60, a);
    u_ixsb_host_model.put_byte(sub, a);
    u_ixsb_host_model.put_byte(d, a);
    u_ixsb_host_model.stop();
    chk("write ack", {15'h0000, eack}, {15'h0000, a});
    chk("write count", {15'h0000, ~eack}, 16'(wr_n - n0));
    chk("write fields", {3'h0, elast}, {3'h0, wr_last});
  endtask : i2c_wr

  // i2c read of channel b fifo twice (master ack, then nack)
  task automatic t_i2c_rd;
    @(negedge core_clk);
    reg_rdata = 8'h96;
    r0 = rd_n;
    u_ixsb_host_model.start();
    u_ixsb_host_model.put_byte(8'h60, a);
    u_ixsb_host_model.put_byte(8'h02, a);
    u_ixsb_host_model.start();
    u_ixsb_host_model.put_byte(8'h61, a);
    chk("read addr ack", 16'h0000, {15'h0000, a});
    u_ixsb_host_model.get_byte(b, 1'b0);
    u_ixsb_host_model.get_byte(b, 1'b1);
    u_ixsb_host_model.stop();
    chk("i2c read data", 16'h0096, {8'h00, b});
    chk("i2c read count", 16'h0002, 16'(rd_n - r0));
    chk("i2c read fields", 16'h0010, {11'h000, rd_last});
  endtask : t_i2c_rd

  // spi write, refused fifo write, then fifo read
  task automatic t_spi;
    @(negedge core_clk);
    tx_full = 2'h1;
    n0 = wr_n;
    u_ixsb_host_model.spi_frame(8'h1A, 8'hC3, b);
    chk("spi write fields", 16'h13C3, {3'h0, wr_last});
    u_ixsb_host_model.spi_frame(8'h00, 8'h11, b);
    // reserved channel code 10: the write must never reach the uart
    u_ixsb_host_model.spi_frame(8'h0C, 8'h22, b);
    chk("spi write count", 16'h0001, 16'(wr_n - n0));
    reg_rdata = 8'h5A;
    r0 = rd_n;
    u_ixsb_host_model.spi_frame(8'h80, 8'h00, b);
    chk("spi read data", 16'h005A, {8'h00, b});
    chk("spi read count", 16'h0001, 16'(rd_n - r0));
    chk("spi so released", 16'h0000, {15'h0000, spi_so_oe});
  endtask : t_spi

  // reset, scenarios in turn, then the verdict
  initial begin
    repeat (4) @(posedge core_clk);
    @(negedge core_clk) reset = 1'b0;
    repeat (10) @(negedge core_clk);
    t_straps();
    up_sel = 2'h0;
    lo_sel = 2'h0;
    tx_full = 2'h2;  // channel b full: only b's fifo write is refused
    i2c_wr(8'hAB, 8'hA5, 1'b0, 13'h15A5);
    i2c_wr(8'h00, 8'h3C, 1'b0, 13'h003C);
    i2c_wr(8'h02, 8'h77, 1'b1, 13'h003C);
    t_i2c_rd();
    t_spi();
    end_of_test();
  end

  // watchdog: a hang counts as a mismatch
  initial begin
    #800000;
    err_total++;
    end_of_test();
  end
endmodule : test_ixsb_slave
